// file: inc/mbox_pkg.sv
package mbox_pkg;
   // mailbox register selects for one host write
   localparam logic [1:0] SEL_CHI = 2'h0;
   localparam logic [1:0] SEL_CLO = 2'h1;
   localparam logic [1:0] SEL_PAR = 2'h2;
   localparam logic [1:0] SEL_HDR = 2'h3;
   // header: channel in [7:6], function in [5:0]
   localparam int         HDR_CH_MSB  = 7;
   localparam int         HDR_CH_LSB  = 6;
   localparam int         HDR_FN_MSB  = 5;
   localparam logic [1:0] CH0 = 2'h0;
   localparam logic [1:0] CH1 = 2'h1;
   localparam logic [1:0] CH2 = 2'h2;
   localparam logic [5:0] FN_BUF     = 6'h24;
   localparam logic [5:0] FN_XCVR    = 6'h25;
   localparam logic [5:0] FN_PUMP    = 6'h26;
   localparam logic [5:0] FN_GPIO    = 6'h2A;
   localparam logic [5:0] FN_VER_REQ = 6'h24;
   localparam logic [5:0] FN_VER_RSP = 6'h25;
   localparam logic [5:0] FN_INVALID = 6'h3F;
   // gpio configuration selects and parameter count
   localparam logic [7:0] GPIO_DRIVE = 8'h20;
   localparam logic [7:0] GPIO_STB  = 8'h30;
   localparam logic [7:0] GPIO_MSK  = 8'h40;
   localparam logic [7:0] GPIO_NPAR = 8'h04;
   // other fixed codes and counts
   localparam logic [7:0] VER_CTRL   = 8'h00;
   localparam logic [7:0] VER_NPAR   = 8'h02;
   localparam logic [7:0] BUF_KEEP   = 8'h00;
   localparam logic [7:0] BUF_NPAR   = 8'h01;
   localparam logic [7:0] NO_PAR     = 8'h00;
   localparam logic [7:0] ONE_PAR    = 8'h01;
   localparam logic [7:0] TWO_PAR    = 8'h02;
   localparam int         PUMP_FAX_BIT = 7;
   localparam int         PMAX_DEF   = 16;
   localparam int         PMAX_MIN   = 11;
   typedef enum logic [1:0] {
      D_COLLECT = 2'b01,
      D_EXEC    = 2'b10
   } dev_state_type;
   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_CLO  = 5'b00010,
      H_PAR  = 5'b00100,
      H_HDR  = 5'b01000,
      H_GAP  = 5'b10000
   } host_state_type;
endpackage

// file: inc/mb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mb_if
(
   input wire logic mclk,
   input wire logic rst
);
   // host to device byte writes
   logic       wr_en;
   logic [1:0] wr_sel;
   logic [7:0] wr_data;
   // device to host message
   logic       rd_valid;
   logic [7:0] rd_hdr;
   logic [7:0] rd_chi;
   logic [7:0] rd_clo;
   logic [7:0] rd_par0;
   logic [7:0] rd_par1;
   modport host
   (
      output wr_en, wr_sel, wr_data,
      input  rd_valid, rd_hdr, rd_chi, rd_clo, rd_par0, rd_par1
   );
   modport dev
   (
      input  wr_en, wr_sel, wr_data,
      output rd_valid, rd_hdr, rd_chi, rd_clo, rd_par0, rd_par1
   );
endinterface
`default_nettype wire

// file: logic/mbox_host.sv
`timescale 1ns/1ps
`default_nettype none
module mbox_host
#(
   parameter int PMAX = mbox_pkg::PMAX_DEF
)
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // mailbox side
   mb_if.host                         mb,
   // command from user
   input  wire logic                  cmd_valid,
   input  wire logic [7:0]            cmd_hdr,
   input  wire logic [7:0]            cmd_chi,
   input  wire logic [7:0]            cmd_clo,
   input  wire logic [PMAX-1:0][7:0]  cmd_par,
   output logic                       cmd_ready,
   output logic                       cmd_refused,
   // message from device
   output logic                       rsp_valid,
   output logic [7:0]                 rsp_hdr,
   output logic [7:0]                 rsp_chi,
   output logic [7:0]                 rsp_clo,
   output logic [7:0]                 rsp_par0,
   output logic [7:0]                 rsp_par1
);
   import mbox_pkg::*;

   if (PMAX < PMAX_MIN || PMAX > 255)
   begin : g_chk
      $error("mbox_host: PMAX out of range");
   end

   typedef struct packed {
      host_state_type    st;
      logic [7:0]        hdr;
      logic [7:0]        chi;
      logic [7:0]        clo;
      logic [PMAX-1:0][7:0] par;
      logic [7:0]        idx;
      logic [1:0]        fax;
      logic              wen;
      logic [1:0]        wsel;
      logic [7:0]        wdat;
      logic              rdy;
      logic              refused;
      logic              rv;
      logic [7:0]        rh;
      logic [7:0]        rc;
      logic [7:0]        rl;
      logic [7:0]        r0;
      logic [7:0]        r1;
   } host_type;

   host_type s_r;
   host_type s_nxt;
   logic     cmd_xcvr;
   logic     cmd_fax_ch;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.wen = 1'b0;
      s_nxt.refused = 1'b0;
      s_nxt.rv = mb.rd_valid;
      if (mb.rd_valid)
      begin
         s_nxt.rh = mb.rd_hdr;
         s_nxt.rc = mb.rd_chi;
         s_nxt.rl = mb.rd_clo;
         s_nxt.r0 = mb.rd_par0;
         s_nxt.r1 = mb.rd_par1;
      end
      cmd_xcvr = cmd_hdr[HDR_FN_MSB:0] == FN_XCVR;
      cmd_fax_ch = (cmd_hdr[HDR_CH_MSB:HDR_CH_LSB] == CH1 && s_r.fax[0])
                || (cmd_hdr[HDR_CH_MSB:HDR_CH_LSB] == CH2 && s_r.fax[1]);
      unique case (s_r.st)
         H_IDLE:
         begin
            if (cmd_valid && s_r.rdy)
            begin
               s_nxt.rdy = 1'b0;
               if ((cmd_xcvr && cmd_fax_ch) || cmd_clo > 8'(PMAX))
               begin
                  s_nxt.refused = 1'b1;
                  s_nxt.st = H_GAP;
               end
               else
               begin
                  s_nxt.hdr = cmd_hdr;
                  s_nxt.chi = cmd_chi;
                  s_nxt.clo = cmd_clo;
                  s_nxt.par = cmd_par;
                  s_nxt.idx = 8'h00;
                  s_nxt.wen = 1'b1;
                  s_nxt.wsel = SEL_CHI;
                  s_nxt.wdat = cmd_chi;
                  s_nxt.st = H_CLO;
               end
            end
         end
         H_CLO:
         begin
            s_nxt.wen = 1'b1;
            s_nxt.wsel = SEL_CLO;
            s_nxt.wdat = s_r.clo;
            s_nxt.st = (s_r.clo == NO_PAR) ? H_HDR : H_PAR;
         end
         H_PAR:
         begin
            s_nxt.wen = 1'b1;
            s_nxt.wsel = SEL_PAR;
            s_nxt.wdat = s_r.par[s_r.idx];
            s_nxt.idx = s_r.idx + 8'h01;
            if (s_r.idx + 8'h01 == s_r.clo)
            begin
               s_nxt.st = H_HDR;
            end
         end
         H_HDR:
         begin
            s_nxt.wen = 1'b1;
            s_nxt.wsel = SEL_HDR;
            s_nxt.wdat = s_r.hdr;
            if (s_r.hdr[HDR_FN_MSB:0] == FN_PUMP)
            begin
               if (s_r.hdr[HDR_CH_MSB:HDR_CH_LSB] == CH1)
               begin
                  s_nxt.fax[0] = s_r.chi[PUMP_FAX_BIT];
               end
               if (s_r.hdr[HDR_CH_MSB:HDR_CH_LSB] == CH2)
               begin
                  s_nxt.fax[1] = s_r.chi[PUMP_FAX_BIT];
               end
            end
            s_nxt.st = H_GAP;
         end
         H_GAP:
         begin
            s_nxt.rdy = 1'b1;
            s_nxt.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.st <= H_IDLE;
         s_r.rdy <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign mb.wr_en = s_r.wen;
   assign mb.wr_sel = s_r.wsel;
   assign mb.wr_data = s_r.wdat;
   assign cmd_ready = s_r.rdy;
   assign cmd_refused = s_r.refused;
   assign rsp_valid = s_r.rv;
   assign rsp_hdr = s_r.rh;
   assign rsp_chi = s_r.rc;
   assign rsp_clo = s_r.rl;
   assign rsp_par0 = s_r.r0;
   assign rsp_par1 = s_r.r1;
endmodule
`default_nettype wire

// file: logic/mbox_device.sv
`timescale 1ns/1ps
`default_nettype none
module mbox_device
#(
   parameter int          PMAX         = mbox_pkg::PMAX_DEF,
   // arbitrary version value
   parameter logic [15:0] CHIP_VERSION = 16'h0001
)
(
   // clock, reset and dl_done
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                dl_done,
   // mailbox side
   mb_if.dev                        mb,
   // buffer settings, index 0 channel 1, index 1 channel 2
   output logic [1:0][7:0]          buf_prio,
   output logic [1:0][7:0]          max_len,
   // transceiver settings
   output logic [1:0][7:0]          xcvr_mode,
   output logic [1:0][7:0]          xcvr_par0,
   output logic [1:0][7:0]          xcvr_par1,
   // pump settings
   output logic [1:0][7:0]          pump_mode,
   output logic [1:0][7:0]          pump_atten,
   // gpio settings
   output logic [8:0]               open_drain_select_bits,
   output logic [8:0]               push_pull_select_bits,
   output logic [8:0]               gpio_strobe_clr,
   output logic [8:0]               gpio_strobe_set,
   output logic [8:0]               gpio_mask_rise,
   output logic [8:0]               gpio_mask_fall,
   // message events
   output logic                     msg_done,
   output logic                     msg_bad
);
   import mbox_pkg::*;

   if (PMAX < PMAX_MIN || PMAX > 255)
   begin : g_chk
      $error("mbox_device: PMAX out of range");
   end

   typedef struct packed {
      dev_state_type        st;
      logic [7:0]           chi;
      logic [7:0]           clo;
      logic [7:0]           hdr;
      logic [7:0]           pcnt;
      logic                 ovf;
      logic [PMAX-1:0][7:0] par;
      logic [1:0][7:0]      prio;
      logic [1:0][7:0]      mlen;
      logic [1:0][7:0]      smode;
      logic [1:0][7:0]      sp0;
      logic [1:0][7:0]      sp1;
      logic [1:0][7:0]      pmode;
      logic [1:0][7:0]      patt;
      logic [8:0]           od;
      logic [8:0]           pp;
      logic [8:0]           stc;
      logic [8:0]           sts;
      logic [8:0]           mr;
      logic [8:0]           mf;
      logic                 done;
      logic                 bad;
      logic                 rv;
      logic [7:0]           rh;
      logic [7:0]           rc;
      logic [7:0]           rl;
      logic [7:0]           r0;
      logic [7:0]           r1;
   } dev_type;

   dev_type    s_r;
   dev_type    s_nxt;
   logic [1:0] ch;
   logic [5:0] fn;
   logic       ci;
   logic       cnt_ok;
   logic       bad;
   logic [8:0] lo9;
   logic [8:0] hi9;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.bad = 1'b0;
      s_nxt.rv = 1'b0;
      bad = 1'b0;
      ch = s_r.hdr[HDR_CH_MSB:HDR_CH_LSB];
      fn = s_r.hdr[HDR_FN_MSB:0];
      ci = (ch == CH2);
      cnt_ok = (s_r.pcnt == s_r.clo) && !s_r.ovf;
      lo9 = {s_r.par[1][0], s_r.par[0]};
      hi9 = {s_r.par[3][0], s_r.par[2]};
      unique case (s_r.st)
         D_COLLECT:
         begin
            if (mb.wr_en)
            begin
               unique case (mb.wr_sel)
                  SEL_CHI: s_nxt.chi = mb.wr_data;
                  SEL_CLO: s_nxt.clo = mb.wr_data;
                  SEL_PAR:
                  begin
                     if (s_r.pcnt < 8'(PMAX))
                     begin
                        s_nxt.par[s_r.pcnt] = mb.wr_data;
                        s_nxt.pcnt = s_r.pcnt + 8'h01;
                     end
                     else
                     begin
                        s_nxt.ovf = 1'b1;
                     end
                  end
                  SEL_HDR:
                  begin
                     s_nxt.hdr = mb.wr_data;
                     s_nxt.st = D_EXEC;
                  end
               endcase
            end
         end
         D_EXEC:
         begin
            if (!cnt_ok)
            begin
               bad = 1'b1;
            end
            else if (ch == CH0 && fn == FN_GPIO)
            begin
               if (s_r.clo != GPIO_NPAR)
               begin
                  bad = 1'b1;
               end
               else if (s_r.chi == GPIO_DRIVE)
               begin
                  s_nxt.od = lo9;
                  s_nxt.pp = hi9;
               end
               else if (s_r.chi == GPIO_STB)
               begin
                  s_nxt.stc = lo9;
                  s_nxt.sts = hi9;
               end
               else if (s_r.chi == GPIO_MSK)
               begin
                  s_nxt.mr = lo9;
                  s_nxt.mf = hi9;
               end
               else
               begin
                  bad = 1'b1;
               end
            end
            else if (ch == CH0 && fn == FN_VER_REQ)
            begin
               if (dl_done || s_r.chi != VER_CTRL || s_r.clo != NO_PAR)
               begin
                  bad = 1'b1;
               end
               else
               begin
                  s_nxt.rv = 1'b1;
                  s_nxt.rh = {CH0, FN_VER_RSP};
                  s_nxt.rc = VER_CTRL;
                  s_nxt.rl = VER_NPAR;
                  s_nxt.r0 = CHIP_VERSION[7:0];
                  s_nxt.r1 = CHIP_VERSION[15:8];
               end
            end
            else if (ch != CH1 && ch != CH2)
            begin
               bad = 1'b1;
            end
            else if (fn == FN_BUF)
            begin
               if (s_r.clo == NO_PAR)
               begin
                  s_nxt.prio[ci] = s_r.chi;
               end
               else if (s_r.clo == BUF_NPAR)
               begin
                  if (s_r.chi != BUF_KEEP)
                  begin
                     s_nxt.prio[ci] = s_r.chi;
                  end
                  s_nxt.mlen[ci] = s_r.par[0];
               end
               else
               begin
                  bad = 1'b1;
               end
            end
            else if (fn == FN_XCVR)
            begin
               if (s_r.pmode[ci][PUMP_FAX_BIT] || s_r.clo > TWO_PAR)
               begin
                  bad = 1'b1;
               end
               else
               begin
                  s_nxt.smode[ci] = s_r.chi;
                  if (s_r.clo >= ONE_PAR)
                  begin
                     s_nxt.sp0[ci] = s_r.par[0];
                  end
                  if (s_r.clo >= TWO_PAR)
                  begin
                     s_nxt.sp1[ci] = s_r.par[1];
                  end
               end
            end
            else if (fn == FN_PUMP)
            begin
               s_nxt.pmode[ci] = s_r.chi;
               if (s_r.clo >= ONE_PAR)
               begin
                  s_nxt.patt[ci] = s_r.par[0];
               end
            end
            else
            begin
               bad = 1'b1;
            end
            if (bad)
            begin
               s_nxt.rv = 1'b1;
               s_nxt.rh = {CH0, FN_INVALID};
               s_nxt.rc = s_r.hdr;
               s_nxt.rl = NO_PAR;
               s_nxt.r0 = 8'h00;
               s_nxt.r1 = 8'h00;
            end
            s_nxt.bad = bad;
            s_nxt.done = !bad;
            s_nxt.pcnt = 8'h00;
            s_nxt.ovf = 1'b0;
            s_nxt.st = D_COLLECT;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.st <= D_COLLECT;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign mb.rd_valid = s_r.rv;
   assign mb.rd_hdr = s_r.rh;
   assign mb.rd_chi = s_r.rc;
   assign mb.rd_clo = s_r.rl;
   assign mb.rd_par0 = s_r.r0;
   assign mb.rd_par1 = s_r.r1;
   assign buf_prio = s_r.prio;
   assign max_len = s_r.mlen;
   assign xcvr_mode = s_r.smode;
   assign xcvr_par0 = s_r.sp0;
   assign xcvr_par1 = s_r.sp1;
   assign pump_mode = s_r.pmode;
   assign pump_atten = s_r.patt;
   assign open_drain_select_bits = s_r.od;
   assign push_pull_select_bits = s_r.pp;
   assign gpio_strobe_clr = s_r.stc;
   assign gpio_strobe_set = s_r.sts;
   assign gpio_mask_rise = s_r.mr;
   assign gpio_mask_fall = s_r.mf;
   assign msg_done = s_r.done;
   assign msg_bad = s_r.bad;
endmodule
`default_nettype wire

// file: tb/mailbox_message_encoding_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mailbox_message_encoding_assertions
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // host writes
   input wire logic       wr_en,
   input wire logic [1:0] wr_sel,
   input wire logic [7:0] wr_data,
   // device messages
   input wire logic       rd_valid,
   input wire logic [7:0] rd_hdr,
   input wire logic [7:0] rd_chi,
   input wire logic [7:0] rd_clo,
   input wire logic [7:0] rd_par0,
   input wire logic [7:0] rd_par1
);
   import mbox_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic       hdr_wr;
   logic [7:0] npar_r;
   logic [7:0] clo_r;
   assign hdr_wr = wr_en && (wr_sel == SEL_HDR);
   // parameter bytes written since the count byte
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         npar_r <= 8'h00;
         clo_r  <= 8'h00;
      end
      else if (wr_en && wr_sel == SEL_CLO)
      begin
         npar_r <= 8'h00;
         clo_r  <= wr_data;
      end
      else if (wr_en && wr_sel == SEL_PAR)
         npar_r <= npar_r + 8'h01;
   end
   a_ctrl_order: assert property (wr_en && wr_sel == SEL_CHI |=>
      wr_en && wr_sel == SEL_CLO) else $error("count byte not after ctrl");
   a_param_next: assert property (wr_en && wr_sel == SEL_CLO |=>
      wr_en && (wr_sel == SEL_PAR || wr_sel == SEL_HDR))
      else $error("gap inside message");
   a_hdr_gap: assert property (hdr_wr |=> !wr_en)
      else $error("write right after header");
   a_count_match: assert property (hdr_wr |-> npar_r == clo_r)
      else $error("parameter count differs from count byte");
   a_answer_cause: assert property (rd_valid |-> $past(hdr_wr, 2))
      else $error("device message without header two cycles before");
   a_rd_pulse: assert property (rd_valid |=> !rd_valid)
      else $error("device message strobe longer than one cycle");
   a_rd_hold: assert property (!rd_valid |-> $stable(rd_hdr) &&
      $stable(rd_chi) && $stable(rd_clo) && $stable(rd_par0))
      else $error("device message changed without strobe");
   a_invalid_fmt: assert property (rd_valid && rd_hdr[5:0] == FN_INVALID
      |-> rd_clo == NO_PAR && rd_chi == $past(wr_data, 2))
      else $error("invalid message format wrong");
   a_ver_resp: assert property (rd_valid && rd_hdr == {CH0, FN_VER_RSP}
      |-> rd_clo == VER_NPAR && rd_chi == VER_CTRL)
      else $error("version response format wrong");
   c_invalid: cover property (rd_valid && rd_hdr[5:0] == FN_INVALID);
   c_version: cover property (rd_valid && rd_hdr == {CH0, FN_VER_RSP});
   c_long_msg: cover property (hdr_wr && clo_r == 8'h0B);
endmodule
`default_nettype wire

// file: tb/mailbox_message_encoding_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mailbox_message_encoding_tb_top;
   import mbox_pkg::*;
   localparam int          P   = 16;
   // arbitrary version value
   localparam logic [15:0] VER = 16'h0001;
   logic                   mclk;
   logic                   rst;
   logic                   dl_done;
   logic                   cmd_valid;
   logic [7:0]             cmd_hdr, cmd_chi, cmd_clo;
   logic [P-1:0][7:0]      cmd_par, p;
   logic                   cmd_ready, cmd_refused, rsp_valid;
   logic [7:0]             rsp_hdr, rsp_chi, rsp_clo, rsp_par0, rsp_par1;
   logic [1:0][7:0]        buf_prio, max_len, xcvr_mode, xcvr_par0;
   logic [1:0][7:0]        xcvr_par1, pump_mode, pump_atten;
   wire logic [5:0][8:0]   gf;
   logic                   msg_done, msg_bad;
   logic [2:0][7:0]        gsel;
   logic [1:0][7:0]        ep, el;
   logic [8:0]             a, b;
   logic [7:0]             pr;
   bit                     ch;
   int                     mismatches, checked;
   mb_if mb(.mclk(mclk), .rst(rst));
   mbox_host #(.PMAX(P)) mbox_host_inst(.mclk, .rst, .mb(mb), .cmd_valid,
      .cmd_hdr, .cmd_chi, .cmd_clo, .cmd_par, .cmd_ready, .cmd_refused,
      .rsp_valid, .rsp_hdr, .rsp_chi, .rsp_clo, .rsp_par0, .rsp_par1);
   mbox_device #(.PMAX(P), .CHIP_VERSION(VER)) mbox_device_inst(.mclk,
      .rst, .dl_done, .mb(mb), .buf_prio, .max_len, .xcvr_mode, .xcvr_par0,
      .xcvr_par1, .pump_mode, .pump_atten, .open_drain_select_bits(gf[0]),
      .push_pull_select_bits(gf[1]), .gpio_strobe_clr(gf[2]),
      .gpio_strobe_set(gf[3]), .gpio_mask_rise(gf[4]),
      .gpio_mask_fall(gf[5]), .msg_done, .msg_bad);
   mailbox_message_encoding_assertions mailbox_message_encoding_assertions_inst
   (
      .mclk(mclk), .rst(rst), .wr_en(mb.wr_en), .wr_sel(mb.wr_sel),
      .wr_data(mb.wr_data), .rd_valid(mb.rd_valid), .rd_hdr(mb.rd_hdr),
      .rd_chi(mb.rd_chi), .rd_clo(mb.rd_clo), .rd_par0(mb.rd_par0),
      .rd_par1(mb.rd_par1)
   );
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // a device message follows a rejection or an accepted version request
   function automatic logic answers(input logic [7:0] h,
                                    input logic [1:0] v);
      return v[1] || (h == {CH0, FN_VER_REQ} && v == 2'b00);
   endfunction
   task automatic conclude();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // verdict code: 00 accepted, 10 rejected, 01 refused by host
   task automatic send(input logic [7:0] h, c, n, input logic [1:0] v);
      int i;
      i = 0;
      while (cmd_ready !== 1'b1)
      begin
         @(negedge mclk);
         i++;
         if (i > 50)
         begin
            mismatches++;
            conclude();
         end
      end
      @(posedge mclk);
      cmd_hdr   <= h;
      cmd_chi   <= c;
      cmd_clo   <= n;
      cmd_par   <= p;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      i = 0;
      do
      begin
         @(negedge mclk);
         i++;
         if (i > 60)
         begin
            mismatches++;
            conclude();
         end
      end
      while (msg_done !== 1'b1 && msg_bad !== 1'b1 && cmd_refused !== 1'b1);
      chk({msg_bad, cmd_refused}, v);
      @(negedge mclk);
      chk(rsp_valid, answers(h, v));
      @(negedge mclk);
   endtask
   initial
   begin
      mismatches = 0;
      checked = 0;
      void'($urandom(32'h9905));
      rst = 1'b1;
      dl_done = 1'b0;
      cmd_valid = 1'b0;
      cmd_hdr = 8'h00;
      cmd_chi = 8'h00;
      cmd_clo = 8'h00;
      cmd_par = '0;
      p = '0;
      ep = {8'h00, 8'h05};
      el = {8'h00, 8'h20};
      gsel = {GPIO_MSK, GPIO_STB, GPIO_DRIVE};
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      p[0] = 8'h20;
      send(8'h64, 8'h05, BUF_NPAR, 2'b00);
      chk(buf_prio[0], 8'h05);
      chk(max_len[0], 8'h20);
      for (int k = 0; k < 6; k++)
      begin
         ch = 1'($urandom_range(1, 0));
         pr = 8'($urandom_range(255, 1));
         p[0] = 8'($urandom);
         ep[ch] = pr;
         el[ch] = p[0];
         send({ch, ~ch, FN_BUF}, pr, BUF_NPAR, 2'b00);
         chk(buf_prio[ch], ep[ch]);
         chk(max_len[ch], el[ch]);
      end
      send(8'hA4, 8'h03, NO_PAR, 2'b00);
      chk(buf_prio[1], 8'h03);
      chk(max_len[1], el[1]);
      p[0] = 8'h20;
      send(8'hA4, BUF_KEEP, ONE_PAR, 2'b00);
      chk(buf_prio[1], 8'h03);
      chk(max_len[1], 8'h20);
      send(8'h64, 8'h07, TWO_PAR, 2'b10);
      chk(buf_prio[0], ep[0]);
      send(8'hE4, 8'h07, ONE_PAR, 2'b10);
      chk(rsp_hdr, {CH0, FN_INVALID});
      chk(rsp_chi, 8'hE4);
      chk(rsp_clo, NO_PAR);
      p[0] = 8'h09;
      send(8'h65, 8'h03, ONE_PAR, 2'b00);
      chk(xcvr_mode[0], 8'h03);
      chk(xcvr_par0[0], 8'h09);
      p[0] = 8'h5D;
      p[1] = 8'h20;
      send(8'hA5, 8'h02, TWO_PAR, 2'b00);
      chk({xcvr_mode[1], xcvr_par0[1]}, 16'h025D);
      chk(xcvr_par1[1], 8'h20);
      p[3:0] = {8'h14, 8'h08, 8'h06, 8'h01};
      send(8'h66, 8'h81, 8'h04, 2'b00);
      chk({pump_mode[0], pump_atten[0]}, 16'h8101);
      p[0] = 8'h07;
      send(8'h65, 8'h02, ONE_PAR, 2'b01);
      chk(xcvr_mode[0], 8'h03);
      p[10:0] = {8'h0E, 8'h06, 8'h08, 8'h00, 8'h02, 8'h00, 8'h00, 8'hF1,
         8'h0F, 8'h82, 8'h00};
      send(8'h66, 8'h42, 8'h0B, 2'b00);
      chk({pump_mode[0], pump_atten[0]}, 16'h4200);
      send(8'h65, 8'h02, ONE_PAR, 2'b00);
      chk(xcvr_mode[0], 8'h02);
      for (int k = 0; k < 3; k++)
      begin
         a = 9'($urandom);
         b = 9'($urandom);
         p[3:0] = {7'h00, b[8], b[7:0], 7'h00, a[8], a[7:0]};
         send({CH0, FN_GPIO}, gsel[k], GPIO_NPAR, 2'b00);
         chk(gf[2*k], a);
         chk(gf[2*k+1], b);
      end
      send({CH0, FN_GPIO}, 8'h50, GPIO_NPAR, 2'b10);
      chk({rsp_hdr, rsp_chi}, {CH0, FN_INVALID, CH0, FN_GPIO});
      send({CH0, FN_GPIO}, GPIO_DRIVE, 8'h03, 2'b10);
      send({CH0, FN_VER_REQ}, VER_CTRL, NO_PAR, 2'b00);
      chk({rsp_hdr, rsp_clo}, {CH0, FN_VER_RSP, VER_NPAR});
      chk({rsp_par1, rsp_par0}, VER);
      @(posedge mclk);
      dl_done <= 1'b1;
      send({CH0, FN_VER_REQ}, VER_CTRL, NO_PAR, 2'b10);
      send(8'h64, 8'h05, 8'h11, 2'b01);
      conclude();
   end
endmodule
`default_nettype wire
